// ---- bench/agu_modulo_bounds_regs_props.sv ----
/* port checker for the address generator bound bank.
   assumes a bind from the bench top file; one clock domain. */
module agu_modulo_bounds_regs_props (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [3:0]  x_circular_pointer_select,
    input wire logic [3:0]  y_circular_pointer_select,
    input wire logic [3:0]  reversed_pointer_select,
    input wire logic [15:0] lower_boundary_field,
    input wire logic [15:0] upper_boundary_field
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // in the assertions, strobes count only while clk_en lets the state advance; c_end_read and c_ptr_req ignore clk_en, c_frozen_wr needs it low
    a_start_bit_zero: assert property (
        lower_boundary_field[0] == 1'b0)
        else $error("start bound bit 0 set");
    a_start_write_lands: assert property (
        clk_en && reg_wr && reg_addr == 3'h1
        |=> lower_boundary_field == ($past(reg_wdata) & 16'hfffe))
        else $error("start bound not written");
    a_end_write_lands: assert property (
        clk_en && reg_wr && reg_addr == 3'h2
        |=> upper_boundary_field[15:1] == $past(reg_wdata[15:1]))
        else $error("end bound not written");
    a_start_read_back: assert property (
        clk_en && reg_rd && reg_addr == 3'h1
        |=> reg_rdata == $past(lower_boundary_field))
        else $error("start bound read wrong");
    a_end_read_one: assert property (
        clk_en && reg_rd && reg_addr == 3'h2
        |=> reg_rdata == ($past(upper_boundary_field) | 16'h0001))
        else $error("end bound read wrong");
    a_start_bound_hold: assert property (
        !(clk_en && reg_wr && reg_addr == 3'h1)
        |=> $stable(lower_boundary_field))
        else $error("start bound changed unasked");
    a_bounds_reset_clear: assert property (
        $rose(rst_n)
        |-> lower_boundary_field == 16'h0000
            && upper_boundary_field == 16'h0000)
        else $error("bounds not clear after reset");
    a_select_follow_mode: assert property (
        clk_en && reg_wr && reg_addr == 3'h0
        |=> {reversed_pointer_select, y_circular_pointer_select,
             x_circular_pointer_select} == $past(reg_wdata[11:0]))
        else $error("selects differ from mode word");
    c_end_read: cover property (reg_rd && reg_addr == 3'h2);
    c_ptr_req: cover property (reg_wr && reg_addr == 3'h4);
    c_frozen_wr: cover property (reg_wr && !clk_en);
endmodule : agu_modulo_bounds_regs_props

// ---- bench/test_agu_modulo_bounds_regs.sv ----
/* self-checking bench for the address generator bound bank.
   assumes the design files and the port checker are compiled first. */
module test_agu_modulo_bounds_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst_n, clk_en, reg_wr, reg_rd;
    logic        rd_d = 1'b0;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, lo_b, up_b, w;
    logic [3:0]  xs, ys, rs;
    logic [15:0] exp_q[$];
    logic [15:0] rev_seq[5] = '{16'ha011, 16'ha009, 16'ha019,
                                16'ha005, 16'ha015};
    int          failures, check_count, cycles, seed;
    agu_modulo_bounds_regs agu_modulo_bounds_regs_inst (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .x_circular_pointer_select(xs), .y_circular_pointer_select(ys),
        .reversed_pointer_select(rs), .lower_boundary_field(lo_b),
        .upper_boundary_field(up_b));
    ////////////////////////////////////////////////////////////////////////
    // one call per cycle, so no strobe is assigned twice in a time step
    task automatic bus(input logic we, input logic re, input logic [2:0] a,
                       input logic [15:0] d);
        reg_wr <= we;
        reg_rd <= re;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask : bus
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask : rd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // read data appear in the cycle after the strobe and hold until the next read, so look there
    always @(posedge core_clk) begin
        if (rd_d) check(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd & clk_en;
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        seed = 32'h46b01966;
        {rst_n, reg_wr, reg_rd} = 3'h0;
        clk_en = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(3'h1, 16'h0000);
        rd(3'h2, 16'h0001);
        rd(3'h6, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            bus(1'b1, 1'b0, 3'h1, w);
            rd(3'h1, w & 16'hfffe);
            bus(1'b1, 1'b0, 3'h2, w);
            rd(3'h2, w | 16'h0001);
        end
        $display("test random bounds done");
        bus(1'b1, 1'b0, 3'h0, 16'hffff);
        rd(3'h0, 16'hcfff);
        bus(1'b1, 1'b0, 3'h0, 16'h01ff); // reversed pointer select = 1
        bus(1'b1, 1'b0, 3'h3, 16'h8008);
        bus(1'b1, 1'b0, 3'h5, 16'ha001); // high bits and bit 0 must survive
        foreach (rev_seq[k]) begin
            bus(1'b1, 1'b0, 3'h4, 16'h0201);
            rd(3'h5, rev_seq[k]);
        end
        $display("test reverse carry done");
        bus(1'b1, 1'b0, 3'h3, 16'h0000);
        bus(1'b1, 1'b0, 3'h0, 16'h8ff2); // circular on, pointer 2
        bus(1'b1, 1'b0, 3'h1, 16'h1000);
        bus(1'b1, 1'b0, 3'h2, 16'h100e);
        bus(1'b1, 1'b0, 3'h5, 16'h100e);
        bus(1'b1, 1'b0, 3'h4, 16'h0202);
        rd(3'h5, 16'h1000);
        bus(1'b1, 1'b0, 3'h4, 16'h0212);
        rd(3'h5, 16'h100e);
        bus(1'b1, 1'b0, 3'h4, 16'h0203);
        rd(3'h5, 16'h1010);
        $display("test circular wrap done");
        clk_en <= 1'b0;
        bus(1'b1, 1'b0, 3'h1, 16'h5554);
        clk_en <= 1'b1;
        bus(1'b1, 1'b0, 3'h7, 16'hffff);
        rd(3'h1, 16'h1000);
        bus(1'b0, 1'b0, 3'h0, 16'h0000);
        repeat (2) @(posedge core_clk);
        $display("test frozen and unmapped writes done");
        stop_test();
    end
endmodule : test_agu_modulo_bounds_regs
bind agu_modulo_bounds_regs agu_modulo_bounds_regs_props props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .x_circular_pointer_select(x_circular_pointer_select),
    .y_circular_pointer_select(y_circular_pointer_select),
    .reversed_pointer_select(reversed_pointer_select),
    .lower_boundary_field(lower_boundary_field),
    .upper_boundary_field(upper_boundary_field));

// ---- design/agu_modulo_bounds_regs.sv ----
/*
 * Control bank for the data-space address generators: mode control,
 * X circular start/end bounds, reverse control, and a pointer update
 * port that applies the selected update to a software-given pointer.
 * Assumes a single-cycle plain register master on core_clk (20 MHz)
 * whose strobes last one cycle and never come together; the bank never
 * stalls the master and has no error response.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Functional notes
// [RL1] start register bits 15..1 hold lower bound, read/write, zero at reset
// [RL2] start register bit 0 always reads zero; writes ignored
// [RL3] end register bits 15..1 hold upper bound, read/write, zero at reset
// [RL4] end register bit 0 always reads one
// [RL5] reverse mode adds modifier with carry moving toward lower bits
// [RL6] bits above pivot unchanged; address bit 0 never changed
// [RL7] modulo pointer past end wraps to start; below start wraps to end
module agu_modulo_bounds_regs (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic      [3:0]  x_circular_pointer_select,
    output logic      [3:0]  y_circular_pointer_select,
    output logic      [3:0]  reversed_pointer_select,
    output logic      [15:0] lower_boundary_field,
    output logic      [15:0] upper_boundary_field
);
    `include "agu_modulo_consts.svh"

    //////////////////////////////////////////////////////////////////////
    // register map, one 16-bit word per offset:
    //   0  mode control: circular and reversed pointer selects, enables
    //   1  circular start bound, bit 0 reads zero
    //   2  circular end bound, bit 0 reads one
    //   3  reverse control: enable and step modifier
    //   4  pointer request, write only; reads return zero
    //   5  pointer value: a write seeds it, a read returns the result
    // the pointer request port lets software drive the same update path
    // the generators use, so the bound and reverse logic can be exercised
    // without a data-space access engine around this bank

    agu_modulo_pkg::word_t mode_ff,   nxt_mode;
    agu_modulo_pkg::word_t xs_ff,     nxt_xs;
    agu_modulo_pkg::word_t xe_ff,     nxt_xe;
    agu_modulo_pkg::word_t rev_ff,    nxt_rev;
    agu_modulo_pkg::word_t result_ff, nxt_result;
    agu_modulo_pkg::word_t rdata_ff,  nxt_rdata;
    agu_modulo_pkg::word_t start_word;
    agu_modulo_pkg::word_t end_word;
    agu_modulo_pkg::word_t rev_sum;
    agu_modulo_pkg::word_t step_val;
    agu_modulo_pkg::word_t lin_next;
    agu_modulo_pkg::word_t mod_next;
    agu_modulo_pkg::word_t over_end;
    agu_modulo_pkg::word_t under_start;
    agu_modulo_pkg::upd_kind_t kind;
    logic [3:0] req_idx;
    logic       req_dec;

    //////////////////////////////////////////////////////////////////////
    // bounds as seen by software reads and the wrap compare: bit 0 forced [RL2] [RL4]
    // the forced bits live only on the read and compare side, so the flops
    // hold nothing that software is not allowed to change
    assign start_word = {xs_ff[15:1], `AGU_START_BIT0}; // [RL2]
    assign end_word   = {xe_ff[15:1], `AGU_END_BIT0};   // [RL4]

    //////////////////////////////////////////////////////////////////////
    // pointer request decode taken from the write data
    // only the low 12 bits of a request mean anything: index, direction
    // and a step of up to 15 bytes
    assign req_idx  = reg_wdata[`AGU_REQ_IDX_LSB +: 4];
    assign req_dec  = reg_wdata[`AGU_REQ_DEC_BIT];
    assign step_val = {12'h000, reg_wdata[`AGU_REQ_STEP_LSB +: 4]};

    // reverse-carry adder works on the stored pointer; the modifier is the
    // low 15 bits of the reverse control word
    agu_reverse_add #(
        .WIDTH (16)
    ) u_rev (
        .ptr      (result_ff),
        .modifier (rev_ff[14:0]),
        .sum      (rev_sum)
    );

    // reverse mode wins over modulo when both pick the same register,
    // matching the way the reverse generator overrides the X write side
    // an X select of all ones means no register; decrement requests never
    // take the reverse path, since reverse order only runs forward
    always_comb begin
        if (rev_ff[`AGU_REV_EN_BIT] && !req_dec
            && reversed_pointer_select == req_idx) begin
            kind = agu_modulo_pkg::UPD_REVERSE;
        end else if (mode_ff[`AGU_X_EN_BIT]
                     && x_circular_pointer_select == req_idx
                     && x_circular_pointer_select != `AGU_SEL_DISABLED) begin
            kind = agu_modulo_pkg::UPD_MODULO;
        end else begin
            kind = agu_modulo_pkg::UPD_LINEAR;
        end
    end

    // plain post-modify of the stored pointer
    assign lin_next = req_dec ? (result_ff - step_val)
                              : (result_ff + step_val);

    //////////////////////////////////////////////////////////////////////
    // circular wrap of the post-modified pointer [RL7]
    // the overshoot past a bound carries into the far end of the buffer,
    // so a step of several bytes still lands on the right entry; a step
    // longer than the whole buffer is folded once only, so software must
    // keep steps no larger than the buffer
    // the end bound is compared with bit 0 set, so a pointer on the last
    // word is inside and the next word is the first one outside
    always_comb begin
        over_end    = lin_next - end_word;
        under_start = start_word - lin_next;
        if (!req_dec && lin_next > end_word) begin
            mod_next = start_word + (over_end - 16'h0001); // [RL7]
        end else if (req_dec && lin_next < start_word) begin
            mod_next = end_word - (under_start - 16'h0001); // [RL7]
        end else begin
            mod_next = lin_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // register writes and pointer update
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_xs     = xs_ff;
        nxt_xe     = xe_ff;
        nxt_rev    = rev_ff;
        nxt_result = result_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                `AGU_OFS_MODE_CONTROL: begin
                    // unimplemented mode bits are masked so they read zero
                    nxt_mode = reg_wdata & `AGU_MODE_IMPL_MASK;
                end
                `AGU_OFS_X_START: begin
                    nxt_xs = {reg_wdata[15:1], 1'b0}; // [RL1] [RL2]
                end
                `AGU_OFS_X_END: begin
                    nxt_xe = {reg_wdata[15:1], 1'b0}; // [RL3]
                end
                `AGU_OFS_REV_CONTROL: begin
                    nxt_rev = reg_wdata;
                end
                `AGU_OFS_PTR_RESULT: begin
                    nxt_result = reg_wdata; // seed the pointer
                end
                `AGU_OFS_PTR_REQ: begin
                    unique case (kind)
                        agu_modulo_pkg::UPD_REVERSE: begin
                            nxt_result = rev_sum; // [RL5] [RL6]
                        end
                        agu_modulo_pkg::UPD_MODULO: begin
                            nxt_result = mod_next; // [RL7]
                        end
                        agu_modulo_pkg::UPD_LINEAR: begin
                            nxt_result = lin_next;
                        end
                    endcase
                end
                // offsets 6 and 7 hold nothing; writes there are dropped
                default: begin
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero
    // the data register keeps its word between reads, so a master that
    // samples late still sees the last answer; bound reads use the forced
    // bit 0 view, not the raw flops
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                `AGU_OFS_MODE_CONTROL: nxt_rdata = mode_ff;
                `AGU_OFS_X_START:      nxt_rdata = start_word; // [RL1]
                `AGU_OFS_X_END:        nxt_rdata = end_word;   // [RL3]
                `AGU_OFS_REV_CONTROL:  nxt_rdata = rev_ff;
                `AGU_OFS_PTR_RESULT:   nxt_rdata = result_ff;
                default:               nxt_rdata = `AGU_RST_WORD;
            endcase
        end
    end

    // all state clears at power-on and freezes while clk_en is low
    // a strobe that meets clk_en low is lost, not held over; the master
    // must repeat it once the enable returns
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff   <= `AGU_RST_WORD;
            xs_ff     <= `AGU_RST_WORD; // [RL1]
            xe_ff     <= `AGU_RST_WORD; // [RL3]
            rev_ff    <= `AGU_RST_WORD;
            result_ff <= `AGU_RST_WORD;
            rdata_ff  <= `AGU_RST_WORD;
        end else if (clk_en) begin
            mode_ff   <= nxt_mode;
            xs_ff     <= nxt_xs;
            xe_ff     <= nxt_xe;
            rev_ff    <= nxt_rev;
            result_ff <= nxt_result;
            rdata_ff  <= nxt_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    // the end bound leaves the raw flop, bit 0 low; generators that need
    // the inclusive last byte add the forced one themselves
    assign reg_rdata                 = rdata_ff;
    assign x_circular_pointer_select = mode_ff[`AGU_XSEL_LSB +: 4];
    assign y_circular_pointer_select = mode_ff[`AGU_YSEL_LSB +: 4];
    assign reversed_pointer_select   = mode_ff[`AGU_RSEL_LSB +: 4];
    assign lower_boundary_field      = xs_ff;
    assign upper_boundary_field      = xe_ff;
endmodule : agu_modulo_bounds_regs

// ---- design/agu_modulo_consts.svh ----
/*
 * Register offsets, field positions, reset values and encodings for the
 * data-space address generator control bank.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef AGU_MODULO_CONSTS_SVH
`define AGU_MODULO_CONSTS_SVH

// word offsets on the plain register port
`define AGU_OFS_MODE_CONTROL    3'h0
`define AGU_OFS_X_START         3'h1
`define AGU_OFS_X_END           3'h2
`define AGU_OFS_REV_CONTROL     3'h3
`define AGU_OFS_PTR_REQ         3'h4
`define AGU_OFS_PTR_RESULT      3'h5

// mode control field positions
`define AGU_XSEL_LSB            0
`define AGU_YSEL_LSB            4
`define AGU_RSEL_LSB            8
`define AGU_X_EN_BIT            15
`define AGU_Y_EN_BIT            14
`define AGU_MODE_IMPL_MASK      16'hcfff

// reverse control: enable in bit 15, modifier in bits 14..0
`define AGU_REV_EN_BIT          15
`define AGU_REV_MOD_MASK        16'h7fff

// pointer request fields: index in 3..0, decrement in 4, step in 11..8
`define AGU_REQ_IDX_LSB         0
`define AGU_REQ_DEC_BIT         4
`define AGU_REQ_STEP_LSB        8

// reset values and forced bit 0 of the bounds
`define AGU_RST_WORD            16'h0000
`define AGU_START_BIT0          1'b0
`define AGU_END_BIT0            1'b1
`define AGU_SEL_DISABLED        4'hf

`endif

// ---- design/agu_modulo_pkg.sv ----
/*
 * Types shared by the address generator control bank.
 * Assumes agu_modulo_consts.svh is compiled alongside.
 */
package agu_modulo_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0]  sel_t;
    typedef enum logic [1:0] {
        UPD_LINEAR,
        UPD_MODULO,
        UPD_REVERSE
    } upd_kind_t;
endpackage : agu_modulo_pkg

// ---- design/agu_reverse_add.sv ----
/*
 * Combinational reverse-carry adder for bit-reversed pointer update.
 * Assumes a word-aligned pointer; bit 0 passes through untouched.
 */
module agu_reverse_add #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] ptr,
    input  wire logic [WIDTH-2:0] modifier,
    output logic      [WIDTH-1:0] sum
);
    logic [WIDTH-1:0] mod_sh;
    logic [WIDTH-1:0] carry;

    // modifier shifted left one place to address words
    assign mod_sh = {modifier, 1'b0};

    //////////////////////////////////////////////////////////////////////
    // carry moves from the top bit toward bit 1 [RL5]
    assign carry[WIDTH-1] = 1'b0;
    genvar i;
    generate
        for (i = WIDTH - 1; i >= 1; i--) begin : g_bit
            assign sum[i] = ptr[i] ^ mod_sh[i] ^ carry[i]; // [RL5]
            if (i > 1) begin : g_c
                assign carry[i-1] = (ptr[i] & mod_sh[i])
                                  | (carry[i] & (ptr[i] ^ mod_sh[i]));
            end
        end
    endgenerate
    // bit 0 never altered; carry past bit 1 is dropped; the top carry-in is zero, so bits above the
    // modifier's pivot see no carry and stay put [RL6]
    assign carry[0] = 1'b0;
    assign sum[0]   = ptr[0]; // [RL6]
endmodule : agu_reverse_add
